// ===== pkg/ivm_regs.svh
// Constants for the interrupt vector mapping block: vectors, addresses and decoder bases.
// Behaviour
// [R1] Flags set on condition, regardless of enable.
// [R2] Each source has its own software enable bit.
// [R3] Request only while enable and flag set.
// [R4] Request holds until its flag clears.
// [R5] Global enable gates every maskable request.
// [R6] Sources of one peripheral share a vector.
// [R7] Vectors 0..29 at word address twice number.
// [R8] Reset, scanner non-maskable, supply monitor first.
// [R9] Vectors 3..12: counter, tick, logic, ports, timer-A.
// [R10] Vectors 13..23: timer-B, two-wire, SPI, serial, analog.
// [R11] Vectors 24..29: port C, timer-B, serial, memory.
// [R12] Decoder selects peripheral from fixed base address.
// [R13] Non-maskable first, then lowest pending vector.
`ifndef IVM_REGS_SVH
`define IVM_REGS_SVH

`define IVM_NUM_VECTORS   30
`define IVM_LAST_VECTOR   29
`define IVM_LAST_ADDR     8'h3A
`define IVM_NMI_VECTOR    1
`define IVM_SRC_PER_VEC   3

`define IVM_BASE_BROWNOUT 16'h0080
`define IVM_BASE_INTCTL   16'h0110
`define IVM_BASE_CRC      16'h0120
`define IVM_BASE_RTC      16'h0140
`define IVM_BASE_LOGIC    16'h01C0
`define IVM_BASE_PORTA    16'h0400
`define IVM_BASE_PORTB    16'h0420
`define IVM_BASE_PORTC    16'h0440
`define IVM_BASE_ADC      16'h0600
`define IVM_BASE_AC       16'h0680
`define IVM_BASE_SER0     16'h0800
`define IVM_BASE_SER1     16'h0820
`define IVM_BASE_TWI      16'h08A0
`define IVM_BASE_SPI      16'h08C0
`define IVM_BASE_TCA      16'h0A00
`define IVM_BASE_TIMB0    16'h0A80
`define IVM_BASE_TIMB1    16'h0A90
`define IVM_BASE_SYSCONF  16'h0F00
`define IVM_BASE_NVM      16'h1000

`endif

// ===== pkg/ivm_pkg.sv
// Types for the interrupt vector mapping block.
package ivm_pkg;
    typedef enum logic [2:0] {
        IVM_IDLE  = 3'b001,
        IVM_OFFER = 3'b010,
        IVM_WAIT  = 3'b100
    } ivm_state_t;

    typedef enum logic [4:0] {
        IVM_SEL_NONE, IVM_SEL_BROWNOUT, IVM_SEL_INTCTL, IVM_SEL_CRC, IVM_SEL_RTC,
        IVM_SEL_LOGIC, IVM_SEL_PORTA, IVM_SEL_PORTB, IVM_SEL_PORTC, IVM_SEL_ADC,
        IVM_SEL_AC, IVM_SEL_SER0, IVM_SEL_SER1, IVM_SEL_TWI, IVM_SEL_SPI,
        IVM_SEL_TCA, IVM_SEL_TIMB0, IVM_SEL_TIMB1, IVM_SEL_SYSCONF, IVM_SEL_NVM
    } ivm_periph_t;
endpackage

// ===== rtl/ivm_vector_map.sv
// Interrupt flags, enables, request gating, vector choice and peripheral address decode.
`timescale 1ns/1ps
`include "ivm_regs.svh"

module ivm_vector_map #(
    parameter int NVEC = `IVM_NUM_VECTORS,
    parameter int NSRC = `IVM_SRC_PER_VEC
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // Peripheral side: condition pulses, flag clears, enable writes
    input  wire logic [NVEC*NSRC-1:0]   source_condition,
    input  wire logic [NVEC*NSRC-1:0]   source_flag_clear,
    input  wire logic                   source_enable_write,
    input  wire logic [NVEC*NSRC-1:0]   source_enable_data,
    input  wire logic                   global_enable,
    // Processor side
    input  wire logic                   vector_ack,
    output logic                        irq_valid,
    output logic                        irq_nmi,
    output logic [4:0]                  irq_vector,
    output logic [7:0]                  irq_address,
    output logic [NVEC*NSRC-1:0]        source_flag_register,
    output logic [NVEC-1:0]             vector_pending,
    // Address decoder
    input  wire logic [15:0]            decode_addr,
    output ivm_pkg::ivm_periph_t        decode_sel
);

    logic [NVEC*NSRC-1:0] flag_q;
    logic [NVEC*NSRC-1:0] source_enable_register_q;
    logic [NVEC-1:0]      pend_d;
    logic [NVEC-1:0]      pend_q;
    logic                 pick_ok;
    logic [4:0]           pick_vec;
    logic                 nmi_waiting;
    ivm_pkg::ivm_state_t  state_q;

    // Word address of a vector entry: two words per entry, counted from zero.
    function automatic logic [7:0] vec_addr(input logic [4:0] n);
        vec_addr = {2'b00, n, 1'b0};
    endfunction

    // Set wins over clear so an event landing with its clear is kept.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flag_q <= '0;
        else
            flag_q <= (flag_q & ~source_flag_clear) | source_condition; // [R1]
    end

    // Enables load as one word, so software keeps a shadow to change single bits;
    // an enable that drops while its vector is offered withdraws that offer.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            source_enable_register_q <= '0;
        else if (source_enable_write)
            source_enable_register_q <= source_enable_data; // [R2]
    end

    // Vector 0 is the reset entry and never requests; slots left unused stay zero.
    genvar v;
    generate
        for (v = 0; v < NVEC; v++)
        begin : g_vec
            logic [NSRC-1:0] live;
            assign live = flag_q[v*NSRC +: NSRC] & source_enable_register_q[v*NSRC +: NSRC]; // [R3]
            if (v == 0)
            begin : g_rst
                assign pend_d[v] = 1'b0; // [R8]
            end
            else if (v == `IVM_NMI_VECTOR)
            begin : g_nmi
                assign pend_d[v] = |live; // [R6]
            end
            else
            begin : g_mask
                assign pend_d[v] = (|live) & global_enable; // [R5] [R6]
            end
        end
    endgenerate

    // The request follows the gated flag level, so it holds until the flag clears, its source enable drops or, on a maskable vector, global enable drops.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pend_q <= '0;
        else
            pend_q <= pend_d; // [R4]
    end

    // Lowest number wins; vector 1 is the non-maskable one so it is first by construction.
    always_comb
    begin
        pick_ok  = 1'b0;
        pick_vec = 5'h0_0;
        for (int i = NVEC - 1; i > 0; i--)
        begin
            if (pend_q[i])
            begin
                pick_ok  = 1'b1;
                pick_vec = 5'(i); // [R13]
            end
        end
    end

    // A non-maskable request withdraws a standing maskable offer, so it never
    // waits behind a core that is slow to acknowledge; the pick that follows
    // finds vector 1 first.
    assign nmi_waiting = pend_q[`IVM_NMI_VECTOR] & ~irq_nmi; // [R13]

    // The offer is frozen while the core is acknowledging, so the vector cannot
    // change under it; a newly pending lower vector is seen at the next offer.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q     <= ivm_pkg::IVM_IDLE;
            irq_valid   <= 1'b0;
            irq_nmi     <= 1'b0;
            irq_vector  <= 5'h0_0;
            irq_address <= 8'h0_0;
        end
        else
        begin
            case (state_q)
                ivm_pkg::IVM_IDLE:
                begin
                    if (pick_ok)
                    begin
                        state_q     <= ivm_pkg::IVM_OFFER;
                        irq_valid   <= 1'b1;
                        irq_nmi     <= (pick_vec == 5'(`IVM_NMI_VECTOR));
                        irq_vector  <= pick_vec;
                        irq_address <= vec_addr(pick_vec); // [R7] [R9] [R10] [R11]
                    end
                end
                ivm_pkg::IVM_OFFER:
                begin
                    if (vector_ack)
                    begin
                        state_q   <= ivm_pkg::IVM_WAIT;
                        irq_valid <= 1'b0;
                        irq_nmi   <= 1'b0;
                    end
                    else if (!pend_q[irq_vector] || nmi_waiting)
                    begin
                        state_q   <= ivm_pkg::IVM_IDLE;
                        irq_valid <= 1'b0; // [R4]
                        irq_nmi   <= 1'b0;
                    end
                end
                // One quiet cycle lets the acknowledged flag clear before the next pick.
                ivm_pkg::IVM_WAIT:
                    state_q <= ivm_pkg::IVM_IDLE;
                default:
                begin
                    state_q   <= ivm_pkg::IVM_IDLE;
                    irq_valid <= 1'b0;
                    irq_nmi   <= 1'b0;
                end
            endcase
        end
    end

    // Registered copies keep every top-level output straight off a flip-flop; they
    // run one cycle behind the live flags and pending bits.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            source_flag_register <= '0;
            vector_pending       <= '0;
        end
        else
        begin
            source_flag_register <= flag_q;
            vector_pending       <= pend_q;
        end
    end

    // Each peripheral owns an address window from its fixed base. Windows never
    // overlap, so OR-ing the hits leaves one select or none; an address outside
    // every window, system memory included, selects nothing.
    function automatic ivm_pkg::ivm_periph_t base_hit(input logic [15:0] a,
                                                      input logic [15:0] base,
                                                      input logic [15:0] span,
                                                      input ivm_pkg::ivm_periph_t id);
        base_hit = (a >= base && a < base + span) ? id : ivm_pkg::IVM_SEL_NONE;
    endfunction

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            decode_sel <= ivm_pkg::IVM_SEL_NONE;
        else
            decode_sel <= ivm_pkg::ivm_periph_t'(
                base_hit(decode_addr, `IVM_BASE_BROWNOUT, 16'h0020, ivm_pkg::IVM_SEL_BROWNOUT)
              | base_hit(decode_addr, `IVM_BASE_INTCTL, 16'h0010, ivm_pkg::IVM_SEL_INTCTL)
              | base_hit(decode_addr, `IVM_BASE_CRC,    16'h0020, ivm_pkg::IVM_SEL_CRC)
              | base_hit(decode_addr, `IVM_BASE_RTC,    16'h0040, ivm_pkg::IVM_SEL_RTC)
              | base_hit(decode_addr, `IVM_BASE_LOGIC,  16'h0040, ivm_pkg::IVM_SEL_LOGIC)
              | base_hit(decode_addr, `IVM_BASE_PORTA,  16'h0020, ivm_pkg::IVM_SEL_PORTA)
              | base_hit(decode_addr, `IVM_BASE_PORTB,  16'h0020, ivm_pkg::IVM_SEL_PORTB)
              | base_hit(decode_addr, `IVM_BASE_PORTC,  16'h0020, ivm_pkg::IVM_SEL_PORTC)
              | base_hit(decode_addr, `IVM_BASE_ADC,    16'h0080, ivm_pkg::IVM_SEL_ADC)
              | base_hit(decode_addr, `IVM_BASE_AC,     16'h0020, ivm_pkg::IVM_SEL_AC)
              | base_hit(decode_addr, `IVM_BASE_SER0,   16'h0020, ivm_pkg::IVM_SEL_SER0)
              | base_hit(decode_addr, `IVM_BASE_SER1,   16'h0020, ivm_pkg::IVM_SEL_SER1)
              | base_hit(decode_addr, `IVM_BASE_TWI,    16'h0020, ivm_pkg::IVM_SEL_TWI)
              | base_hit(decode_addr, `IVM_BASE_SPI,    16'h0020, ivm_pkg::IVM_SEL_SPI)
              | base_hit(decode_addr, `IVM_BASE_TCA,    16'h0080, ivm_pkg::IVM_SEL_TCA)
              | base_hit(decode_addr, `IVM_BASE_TIMB0,  16'h0010, ivm_pkg::IVM_SEL_TIMB0)
              | base_hit(decode_addr, `IVM_BASE_TIMB1,  16'h0010, ivm_pkg::IVM_SEL_TIMB1)
              | base_hit(decode_addr, `IVM_BASE_SYSCONF, 16'h0100, ivm_pkg::IVM_SEL_SYSCONF)
              | base_hit(decode_addr, `IVM_BASE_NVM,    16'h0100, ivm_pkg::IVM_SEL_NVM)); // [R12]
    end

endmodule

// ===== verification/ivm_vector_map_assertions.sv
// Checker for flag, offer and acknowledge timing.
`timescale 1ns/1ps
module ivm_vector_map_assertions #(
    parameter int NVEC = 30,
    parameter int NSRC = 3
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 resetn,
    // Peripheral side
    input wire logic [NVEC*NSRC-1:0] source_condition,
    input wire logic [NVEC*NSRC-1:0] source_flag_clear,
    input wire logic [NVEC*NSRC-1:0] source_flag_register,
    input wire logic                 global_enable,
    // Processor side
    input wire logic                 vector_ack,
    input wire logic                 irq_valid,
    input wire logic                 irq_nmi,
    input wire logic [4:0]           irq_vector,
    input wire logic [NVEC-1:0]      vector_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_new_flag: assert property ((source_flag_register & ~$past(source_flag_register)
        & ~$past(source_condition, 2)) == '0) else $error("flag without cause");
    a_flag_hold: assert property ((~source_flag_register & $past(source_flag_register)
        & ~$past(source_flag_clear, 2)) == '0) else $error("flag lost");
    a_offer_pend: assert property ($rose(irq_valid) |-> vector_pending[irq_vector])
        else $error("offer not pending");
    a_global_gate: assert property ((!global_enable)[*4] |-> !irq_valid || irq_nmi)
        else $error("offer while masked");
    a_nmi_flag: assert property (irq_valid |-> irq_nmi == (irq_vector == 5'h1))
        else $error("nmi flag wrong");
    a_vec_range: assert property (irq_valid |-> irq_vector inside {[5'd1:5'd29]})
        else $error("vector out of range");
    a_ack_drop: assert property (irq_valid && vector_ack |=> !irq_valid [*2])
        else $error("offer kept after ack");
    a_offer_fixed: assert property (irq_valid && $past(irq_valid) |-> $stable(irq_vector))
        else $error("offer changed");

    c_ack: cover property (irq_valid && vector_ack);
    c_nmi: cover property (irq_valid && irq_nmi);
    c_drop: cover property ($fell(irq_valid) && !$past(vector_ack));
endmodule

bind ivm_vector_map ivm_vector_map_assertions #(.NVEC(NVEC), .NSRC(NSRC)) u_chk (.*);

// ===== verification/ivm_core_model.sv
// Processor core stand-in that accepts offered vectors after a lag.
`timescale 1ns/1ps
module ivm_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Offer and controls
    input  wire logic       irq_valid,
    input  wire logic       stall,
    input  wire logic [1:0] lag,
    // Acceptance
    output logic            vector_ack
);
    logic [1:0] wait_q;

    // A one-cycle pulse, raised only under a standing offer.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vector_ack <= 1'b0;
            wait_q <= 2'd0;
        end
        else
        begin
            vector_ack <= irq_valid && !vector_ack && !stall && wait_q == lag;
            wait_q <= (irq_valid && !vector_ack) ? wait_q + 2'd1 : 2'd0;
        end
    end
endmodule

// ===== verification/interrupt_vector_mapping_tb.sv
// Self-checking bench for the interrupt vector mapping block.
`timescale 1ns/1ps
module interrupt_vector_mapping_tb;
    logic        clk = 1'b0;
    logic        resetn, en_wr, glob, stall, ack, valid, nmi;
    logic [89:0] cond, man_clr, en_data, flags;
    logic [89:0] ack_clr = '0;
    logic [29:0] pend;
    logic [4:0]  vec;
    logic [7:0]  addr_o;
    logic [15:0] addr;
    logic [1:0]  lag = 2'd0;
    int          err_total, n_checks, cyc, v, s, k, e;
    int          q [$];
    ivm_pkg::ivm_periph_t sel;
    logic [15:0] da [5] = '{16'h0110, 16'h0F00, 16'h1000, 16'h0A90, 16'hFFFF};
    ivm_pkg::ivm_periph_t ds [5] = '{ivm_pkg::IVM_SEL_INTCTL, ivm_pkg::IVM_SEL_SYSCONF,
        ivm_pkg::IVM_SEL_NVM, ivm_pkg::IVM_SEL_TIMB1, ivm_pkg::IVM_SEL_NONE};

    ivm_vector_map dut (.clk(clk), .resetn(resetn), .source_condition(cond),
        .source_flag_clear(man_clr | ack_clr), .source_enable_write(en_wr),
        .source_enable_data(en_data), .global_enable(glob), .vector_ack(ack),
        .irq_valid(valid), .irq_nmi(nmi), .irq_vector(vec), .irq_address(addr_o),
        .source_flag_register(flags), .vector_pending(pend), .decode_addr(addr),
        .decode_sel(sel));
    ivm_core_model u_core (.clk(clk), .resetn(resetn), .irq_valid(valid), .stall(stall),
        .lag(lag), .vector_ack(ack));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_en(input logic [89:0] d);
        en_data = d;
        en_wr = 1;
        @(negedge clk);
        en_wr = 0;
    endtask

    // Waits for the core to take every noted vector, with a bound.
    task automatic drain();
        int t;
        for (t = 0; t < 1000 && q.size() > 0; t++)
            @(negedge clk);
        chk("left", 0, q.size());
    endtask

    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end

    // Each accepted offer is compared mid-cycle with the oldest note. Its flags are
    // cleared in the same cycle, so the pick after the quiet cycle cannot see it again.
    always @(negedge clk)
    begin
        lag = 2'($urandom_range(3, 0));
        if (resetn === 1'b1 && valid === 1'b1 && ack === 1'b1)
        begin
            e = (q.size() > 0) ? q.pop_front() : 31;
            chk("vector", e, vec);
            chk("address", e * 2, addr_o);
            chk("nmi", e == 1, nmi);
            ack_clr = 90'h7 << (e * 3);
        end
        else
            ack_clr = '0;
    end

    initial
    begin
        void'($urandom(32'h41bef371));
        {resetn, en_wr, glob, stall, cond, man_clr, en_data, addr} = 0;
        repeat (6) @(negedge clk);
        resetn = 1;
        @(negedge clk);
        v = $urandom_range(29, 2);
        s = $urandom_range(2, 0) + v * 3;
        glob = 1;
        stall = 1;
        cond[s] = 1;
        @(negedge clk);
        cond = '0;
        repeat (4) @(negedge clk);
        chk("flag", 1, flags[s]);
        chk("valid", 0, valid);
        wr_en(90'h1 << s);
        repeat (4) @(negedge clk);
        chk("vector", v, vec);
        chk("pending", 1, pend[v]);
        chk("valid", 1, valid);
        glob = 0;
        repeat (4) @(negedge clk);
        chk("valid", 0, valid);
        glob = 1;
        repeat (10) @(negedge clk);
        chk("valid", 1, valid);
        man_clr[s] = 1;
        @(negedge clk);
        man_clr = '0;
        repeat (4) @(negedge clk);
        chk("valid", 0, valid);
        stall = 0;
        wr_en('1);
        glob = 0;
        for (k = 0; k < 30; k++)
            cond[k * 3 + $urandom_range(2, 0)] = 1;
        @(negedge clk);
        cond = '0;
        q.push_back(1);
        drain();
        repeat (8) @(negedge clk);
        chk("valid", 0, valid);
        for (k = 2; k < 30; k++)
            q.push_back(k);
        glob = 1;
        drain();
        for (k = 0; k < 5; k++)
        begin
            addr = da[k];
            @(negedge clk);
            chk("select", ds[k], sel);
        end
        summarize();
    end
endmodule
